// File: src/dsag_pkg.sv
/*
  Shared constants and carrier types for the data space address
  generation and stack checking block.
  Assumes a 16-bit data space, 24-bit program addresses, 25 MHz clock.
*/
package dsag_pkg;

  // ==========================================================
  // Register map (Avalon-MM word offsets as byte addresses)
  // ==========================================================
  localparam logic [3:0]  OFS_STACK_LIMIT = 4'h0;
  localparam logic [3:0]  OFS_TABLE_PAGE  = 4'h4;
  localparam logic [3:0]  OFS_STATUS_LOW  = 4'h8;
  localparam logic [3:0]  OFS_STACK_PTR   = 4'hC;
  localparam logic [3:0]  OFS_TRAP_COUNT  = 4'h0; // unused alias guard

  // ==========================================================
  // Address space constants
  // ==========================================================
  localparam logic [23:0] PROG_USER_MAX   = 24'h7F_FFFE;
  localparam int          PROG_CFG_BIT    = 23;
  localparam int          TBLPAGE_CFG_BIT = 7;
  localparam logic [15:0] NEAR_MAX        = 16'h1FFF;
  localparam logic [15:0] STACK_FLOOR     = 16'h0800;
  localparam logic [15:0] Y_BASE_DEF      = 16'h0800;
  localparam logic [15:0] Y_END_DEF       = 16'h0FFF;
  localparam logic [15:0] MEM_TOP_DEF     = 16'h0FFF;
  localparam logic [15:0] ZERO_WORD       = 16'h0000;
  localparam logic [15:0] WORD_STEP       = 16'h0002;
  localparam logic [15:0] STACK_LIMIT_RST = 16'h0000;

  // ==========================================================
  // Access kinds issued by the execute stage
  // ==========================================================
  typedef enum logic [2:0]
  {
    ACC_NONE  = 3'b000,
    ACC_READ  = 3'b001,
    ACC_WRITE = 3'b010,
    ACC_PUSH  = 3'b011,
    ACC_POP   = 3'b100,
    ACC_MAC   = 3'b101
  } dsag_acc_e;

  // Push word source
  typedef enum logic [1:0]
  {
    PSH_DATA  = 2'b00,
    PSH_PCLO  = 2'b01,
    PSH_CALL  = 2'b10,
    PSH_EXC   = 2'b11
  } dsag_psh_e;

  // Data request from execute stage
  typedef struct packed
  {
    dsag_acc_e   kind;
    logic        byteOp;
    logic        direct13;
    logic        direct16;
    logic        bitRev;
    logic [15:0] ea;
    logic [15:0] wdata;
    dsag_psh_e   pushSrc;
    logic [23:0] pc;
  } dsag_req_s;

  // Dual MAC prefetch pointers
  typedef struct packed
  {
    logic [15:0] xPtr;
    logic [15:0] yPtr;
  } dsag_mac_s;

  // Program space request
  typedef struct packed
  {
    logic        valid;
    logic        tableAcc;
    logic [23:0] addr;
  } dsag_preq_s;

endpackage

// File: src/dsag_agu.sv
/*
  Address generation and checking for data and program space, with the
  software stack limit and underflow checks.
  Assumes the execute stage presents one request per cycle and that the
  memory arrays outside return raw data for the addresses driven here.
*/
//
// Contract
// - User program access 0x000000..0x7FFFFE; table ops pick by page bit 7.
// - Program address bit 23 set only for ID and configuration accesses.
// - Program space 4M words, consecutive words two address units apart.
// - X block covers whole space except Y region for MAC reads.
// - MAC reads Y via W10/W11 and X via W8/W9 concurrently.
// - No writes over Y path; all writes use X path anywhere.
// - Bit reversal only on X writes; modulo in both X and Y.
// - Out-of-space or unimplemented reads return all zeros.
// - Misaligned word read or write raises address error trap.
// - Misaligned read completes; misaligned write is suppressed; then trap.
// - Byte load into working register updates low byte only.
// - Direct 13-bit field reaches 0x0000..0x1FFF; 16-bit reaches all X.
// - Stack pointer grows upward; post-increment push, pre-decrement pop.
// - Call pushes PC upper byte zero-extended, MSB clear.
// - Exception push places status low byte beside PC upper byte.
// - Stack limit uninitialised at reset; bit 0 always reads zero.
// - Stack EAs compared with limit; push at equal passes, next traps.
// - Stack pointer below 0x0800 raises stack error trap.
// - X/Y boundary fixed in hardware, not software movable.
`timescale 1ns/1ps

module dsag_agu
  import dsag_pkg::*;
#(
  parameter logic [15:0] Y_BASE  = Y_BASE_DEF,
  parameter logic [15:0] Y_END   = Y_END_DEF,
  parameter logic [15:0] MEM_TOP = MEM_TOP_DEF
)
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // Avalon-MM register slave
  input  wire logic [3:0]           avsAddress,
  input  wire logic                 avsRead,
  input  wire logic                 avsWrite,
  input  wire logic [31:0]          avsWriteData,
  input  wire logic [3:0]           avsByteEnable,
  output logic [31:0]               avsReadData,
  output logic                      avsWaitRequest,
  // Execute stage data request
  input  wire dsag_pkg::dsag_req_s  req,
  input  wire logic [15:0]          modStart,
  input  wire logic [15:0]          modEnd,
  input  wire logic                 modEnable,
  input  wire logic [15:0]          regOld,
  // MAC prefetch pointers
  input  wire dsag_pkg::dsag_mac_s  mac,
  // Program space request
  input  wire dsag_pkg::dsag_preq_s preq,
  // Memory side
  input  wire logic [15:0]          xMemRdata,
  input  wire logic [15:0]          yMemRdata,
  output logic [15:0]               xAddr,
  output logic [15:0]               yAddr,
  output logic                      xWrite,
  output logic [15:0]               xWdata,
  output logic [23:0]               progAddr,
  output logic                      progValid,
  // Results
  output logic [15:0]               xRdata,
  output logic [15:0]               yRdata,
  output logic [15:0]               regLoad,
  // Trap requests
  output logic                      addrErrTrap,
  output logic                      stackErrTrap
);

  // ==========================================================
  // Register bus
  // ==========================================================
  logic [15:0] stackLimit_reg;
  logic [7:0]  tablePage_reg;
  logic [7:0]  statusLow_reg;
  logic [15:0] stackPtr_reg;
  logic        rdDone_reg;
  logic [31:0] rdData_reg;

  // Address decode
  wire selLimit = avsAddress == OFS_STACK_LIMIT;
  wire selPage  = avsAddress == OFS_TABLE_PAGE;
  wire selStat  = avsAddress == OFS_STATUS_LOW;
  wire selSp    = avsAddress == OFS_STACK_PTR;
  wire wrLimit  = avsWrite && selLimit;
  wire wrPage   = avsWrite && selPage && avsByteEnable[0];
  wire wrStat   = avsWrite && selStat && avsByteEnable[0];
  wire wrSp     = avsWrite && selSp;

  // Writes finish at once, reads wait one cycle
  assign avsWaitRequest = avsRead && !rdDone_reg;
  assign avsReadData    = rdData_reg;

  // Read mux; unmapped offsets return zero
  wire [31:0] rdMux =
      selLimit ? {16'h0000, stackLimit_reg[15:1], 1'b0} :
      selPage  ? {24'h00_0000, tablePage_reg} :
      selStat  ? {24'h00_0000, statusLow_reg} :
      selSp    ? {16'h0000, stackPtr_reg} : 32'h0000_0000;

  // Read handshake
  always_ff @(posedge clk)
  begin
    if (reset)
      rdDone_reg <= 1'b0;
    else
      rdDone_reg <= avsRead && !rdDone_reg;
    rdData_reg <= rdMux;
  end

  // Stack limit has no reset value; bit 0 held at zero
  logic [15:0] limitMerged;
  assign limitMerged = {avsByteEnable[1] ? avsWriteData[15:8]
                                         : stackLimit_reg[15:8],
                        avsByteEnable[0] ? avsWriteData[7:1]
                                         : stackLimit_reg[7:1],
                        1'b0};
  always_ff @(posedge clk)
  begin
    if (wrLimit)
      stackLimit_reg <= limitMerged;
  end

  // Page and status registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tablePage_reg <= 8'h00;
      statusLow_reg <= 8'h00;
    end
    else
    begin
      if (wrPage)
        tablePage_reg <= avsWriteData[7:0];
      if (wrStat)
        statusLow_reg <= avsWriteData[7:0];
    end
  end

  // ==========================================================
  // Program space addressing
  // ==========================================================
  // Table ops pick config space by page bit 7; others stay in user space
  wire cfgAcc = preq.tableAcc && tablePage_reg[TBLPAGE_CFG_BIT];
  wire [23:0] progUser = preq.addr & PROG_USER_MAX;
  wire [23:0] progNext = {cfgAcc, progUser[22:1], 1'b0};

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      progAddr  <= 24'h00_0000;
      progValid <= 1'b0;
    end
    else
    begin
      progAddr  <= progNext;
      progValid <= preq.valid;
    end
  end

  // ==========================================================
  // Effective address shaping
  // ==========================================================
  // Bit reversal of the destination index
  function automatic logic [15:0] bitRev16(input logic [15:0] a);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
      r[i] = a[15 - i];
    return r;
  endfunction

  // Modulo wrap applied when the EA leaves the buffer
  function automatic logic [15:0] modWrap(input logic [15:0] a,
                                          input logic        en,
                                          input logic [15:0] s,
                                          input logic [15:0] e);
    logic [15:0] r;
    r = a;
    if (en && a > e)
      r = s + (a - e - WORD_STEP);
    else if (en && a < s)
      r = e - (s - a - WORD_STEP);
    return r;
  endfunction

  wire isWrite = req.kind == ACC_WRITE;
  wire isRead  = req.kind == ACC_READ;
  wire isPush  = req.kind == ACC_PUSH;
  wire isPop   = req.kind == ACC_POP;
  wire isMac   = req.kind == ACC_MAC;

  // Direct field widths
  wire [15:0] eaDirect = req.direct13 ? {3'b000, req.ea[12:0]}
                                      : req.ea;
  // Bit reversal only for X writes
  wire [15:0] eaRev = (isWrite && req.bitRev) ? bitRev16(eaDirect)
                                              : eaDirect;
  wire [15:0] eaData = modWrap(eaRev, modEnable && !req.bitRev,
                               modStart, modEnd);

  // Stack pointer address and update
  wire [15:0] spPopEa  = stackPtr_reg - WORD_STEP;
  wire [15:0] stackEa  = isPop ? spPopEa : stackPtr_reg;
  wire [15:0] spNext   = isPush ? stackPtr_reg + WORD_STEP :
                         isPop  ? spPopEa : stackPtr_reg;

  // MAC pointers; Y also supports modulo
  wire [15:0] macX = mac.xPtr;
  wire [15:0] macY = modWrap(mac.yPtr, modEnable,
                             modStart, modEnd);

  // ==========================================================
  // Space checks
  // ==========================================================
  // Fixed boundary; parameters only
  wire yHitX   = macX >= Y_BASE && macX <= Y_END;
  wire yInY    = macY >= Y_BASE && macY <= Y_END;
  wire xOutMac = yHitX || macX > MEM_TOP;
  wire yOut    = !yInY;
  wire [15:0] dataEa = (isPush || isPop) ? stackEa : eaData;
  wire dataOut = dataEa > MEM_TOP;

  // Alignment
  wire wordAcc   = !req.byteOp || isPush || isPop;
  wire misRead   = (isRead || isPop) && wordAcc && dataEa[0];
  wire misWrite  = (isWrite || isPush) && wordAcc && dataEa[0];
  wire misMac    = isMac && (macX[0] || macY[0]);

  // Stack checks
  wire stackUse  = isPush || isPop;
  wire overLimit = isPush && stackPtr_reg > stackLimit_reg;
  wire underFlow = stackUse && stackEa < STACK_FLOOR;

  // ==========================================================
  // Push word formation
  // ==========================================================
  logic [15:0] pushWord;
  always_comb
  begin
    case (req.pushSrc)
      PSH_DATA: pushWord = req.wdata;
      PSH_PCLO: pushWord = req.pc[15:0];
      PSH_CALL: pushWord = {8'h00, 1'b0, req.pc[22:16]};
      PSH_EXC:  pushWord = {statusLow_reg, 1'b0, req.pc[22:16]};
      default:  pushWord = req.wdata;
    endcase
  end

  // ==========================================================
  // Memory side drive
  // ==========================================================
  // All writes use the X path; Y never written
  assign xAddr  = isMac ? macX : dataEa;
  assign yAddr  = macY;
  assign xWrite = (isWrite || isPush) && !misWrite && !dataOut;
  assign xWdata = isPush ? pushWord : req.wdata;

  // Read data with zero substitution
  wire [15:0] xRaw = isMac ? (xOutMac ? ZERO_WORD : xMemRdata)
                           : (dataOut ? ZERO_WORD : xMemRdata);
  wire [15:0] yRaw = (isMac && !yOut) ? yMemRdata : ZERO_WORD;
  // Byte select within the addressed word
  wire [7:0]  xByte = dataEa[0] ? xRaw[15:8] : xRaw[7:0];
  // Byte load keeps the high byte of the target
  wire [15:0] loadVal = req.byteOp ? {regOld[15:8], xByte}
                                   : xRaw;

  // ==========================================================
  // Registered results, stack pointer and traps
  // ==========================================================
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      xRdata       <= 16'h0000;
      yRdata       <= 16'h0000;
      regLoad      <= 16'h0000;
      addrErrTrap  <= 1'b0;
      stackErrTrap <= 1'b0;
    end
    else
    begin
      xRdata       <= xRaw;
      yRdata       <= yRaw;
      regLoad      <= loadVal;
      addrErrTrap  <= misRead || misWrite || misMac;
      stackErrTrap <= overLimit || underFlow;
    end
  end

  // Stack pointer; bus write has priority over stack traffic
  always_ff @(posedge clk)
  begin
    if (reset)
      stackPtr_reg <= STACK_FLOOR;
    else if (wrSp)
      stackPtr_reg <= {avsWriteData[15:1], 1'b0};
    else
      stackPtr_reg <= spNext;
  end

endmodule

// File: tb/dsag_agu_asserts.sv
/*
  Port checks on the address unit, one clock domain.
  Assumes a bind from the bench top file.
*/
`timescale 1ns/1ps
module dsag_agu_asserts
  import dsag_pkg::*;
#(
  parameter logic [15:0] Y_BASE  = Y_BASE_DEF,
  parameter logic [15:0] Y_END   = Y_END_DEF,
  parameter logic [15:0] MEM_TOP = MEM_TOP_DEF
)
(
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 reset,
  // Register bus
  input wire logic [3:0]           avsAddress,
  input wire logic                 avsRead,
  input wire logic [31:0]          avsReadData,
  input wire logic                 avsWaitRequest,
  // Requests
  input wire dsag_pkg::dsag_req_s  req,
  input wire logic [15:0]          regOld,
  input wire dsag_pkg::dsag_mac_s  mac,
  input wire dsag_pkg::dsag_preq_s preq,
  // Results
  input wire logic [15:0]          yAddr,
  input wire logic                 xWrite,
  input wire logic [15:0]          xWdata,
  input wire logic [23:0]          progAddr,
  input wire logic [15:0]          xRdata,
  input wire logic [15:0]          regLoad,
  input wire logic                 addrErrTrap,
  input wire logic                 stackErrTrap
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ==========================================================
  // Helper decodes
  // ==========================================================
  wire wordMis = !req.byteOp && req.ea[0];
  wire xInY    = mac.xPtr >= Y_BASE && mac.xPtr <= Y_END && !mac.xPtr[0];
  wire yInY    = mac.yPtr >= Y_BASE && mac.yPtr <= Y_END && !mac.yPtr[0];
  // ==========================================================
  // Assertions
  // ==========================================================
  wr_suppress_a : assert property (
    req.kind == ACC_WRITE && wordMis |-> !xWrite ##1 addrErrTrap)
    else $error("misaligned write stored or not trapped");
  rd_misalign_a : assert property (
    req.kind == ACC_READ && wordMis |=> addrErrTrap)
    else $error("misaligned read not trapped");
  trap_split_a : assert property (
    req.kind == ACC_READ && !wordMis && req.ea <= MEM_TOP
    |=> !addrErrTrap && !stackErrTrap) else $error("spurious trap");
  write_path_a : assert property (
    xWrite |-> req.kind == ACC_WRITE || req.kind == ACC_PUSH)
    else $error("write strobe without write request");
  byte_load_a : assert property (
    req.kind == ACC_READ && req.byteOp
    |=> regLoad[15:8] == $past(regOld[15:8])) else $error("high byte lost");
  mac_xzero_a : assert property (
    req.kind == ACC_MAC && xInY |=> xRdata == ZERO_WORD)
    else $error("X pointer into Y region read nonzero");
  mac_ypath_a : assert property (
    req.kind == ACC_MAC && yInY |-> yAddr == mac.yPtr)
    else $error("Y pointer not on Y path");
  prog_fmt_a : assert property (
    preq.valid && !preq.tableAcc |=> !progAddr[23] && !progAddr[0])
    else $error("program address format wrong");
  limit_bit_a : assert property (
    avsRead && !avsWaitRequest && avsAddress == OFS_STACK_LIMIT
    |-> !avsReadData[0]) else $error("limit bit 0 set");
  call_push_a : assert property (
    req.kind == ACC_PUSH && req.pushSrc == PSH_CALL
    |-> xWdata == {8'h00, 1'b0, req.pc[22:16]})
    else $error("call push word");
  // Main scenarios reached
  mis_wr_c : cover property (req.kind == ACC_WRITE && wordMis);
  mac_c : cover property (req.kind == ACC_MAC && xInY);
  exc_c : cover property (req.kind == ACC_PUSH && req.pushSrc == PSH_EXC);
endmodule

// File: tb/dsag_mem_model.sv
/*
  X and Y memory read ports beside the address unit.
  Assumes combinational reads; contents follow an address pattern.
*/
`timescale 1ns/1ps
module dsag_mem_model
(
  // Addresses from the unit
  input  wire logic [15:0] xAddr,
  input  wire logic [15:0] yAddr,
  // Read data back
  output logic [15:0]      xMemRdata,
  output logic [15:0]      yMemRdata
);
  // Word pattern differs per address so stale values show
  assign xMemRdata = {8'h3C ^ {xAddr[7:1], 1'b0}, xAddr[15:8] ^ 8'hC3};
  assign yMemRdata = {8'h3C ^ {yAddr[7:1], 1'b0}, yAddr[15:8] ^ 8'hC3};
endmodule

// File: tb/testbench.sv
/*
  Self-checking bench: register bus, data, stack and program paths.
  Assumes the package, unit, memory model and checker are compiled.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("MISMATCH %0t got %h exp %h", $time, g, e); \
  end end
module testbench;
  import dsag_pkg::*;
  typedef struct {int due; int sel; logic [23:0] exp;} dsag_note_s;
  logic        clk = 1'b0, reset = 1'b1, avsRead = 1'b0, avsWrite = 1'b0;
  logic [3:0]  avsAddress = 4'h0;
  logic [31:0] avsWriteData = 32'h0000_0000, avsReadData, rd;
  logic        avsWaitRequest, xWrite, progValid, addrErrTrap, stackErrTrap;
  logic        modEnable = 1'b0;
  logic [15:0] regOld, xMemRdata, yMemRdata, xAddr, yAddr, xWdata, a, m;
  logic [15:0] xRdata, yRdata, regLoad;
  logic [23:0] progAddr, pcVal, pa;
  dsag_req_s   req = '0;
  dsag_mac_s   mac = '0;
  dsag_preq_s  preq = '0;
  int          n_mismatch = 0, check_count = 0, ncyc = 0;
  dsag_note_s  q[$];
  // Unit, memory model
  dsag_agu dut (.clk(clk), .reset(reset), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(4'hF), .avsReadData(avsReadData), .req(req),
    .avsWaitRequest(avsWaitRequest), .modStart(16'h0A00), .mac(mac),
    .modEnd(16'h0A0E), .modEnable(modEnable), .regOld(regOld), .preq(preq),
    .xMemRdata(xMemRdata), .yMemRdata(yMemRdata), .xAddr(xAddr),
    .yAddr(yAddr), .xWrite(xWrite), .xWdata(xWdata), .progAddr(progAddr),
    .progValid(progValid), .xRdata(xRdata), .yRdata(yRdata),
    .regLoad(regLoad), .addrErrTrap(addrErrTrap),
    .stackErrTrap(stackErrTrap));
  dsag_mem_model mem (.xAddr(xAddr), .yAddr(yAddr),
    .xMemRdata(xMemRdata), .yMemRdata(yMemRdata));
  // Clock
  initial
  begin
    forever #20 clk = ~clk;
  end
  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [15:0] mw(logic [15:0] ad);
    mw = {8'h3C ^ {ad[7:1], 1'b0}, ad[15:8] ^ 8'hC3};
  endfunction
  function automatic logic [23:0] pick(int s);
    case (s)
      0: pick = {8'h00, xRdata};
      1: pick = {8'h00, regLoad};
      2: pick = {22'h0, addrErrTrap, stackErrTrap};
      3: pick = progAddr;
      4: pick = {8'h00, yRdata};
      5: pick = {7'h00, xWrite, xAddr};
      6: pick = {8'h00, xWdata};
      default: pick = {23'h0, xWrite};
    endcase
  endfunction
  task automatic note(int s, int d, logic [23:0] e);
    q.push_back('{ncyc + d, s, e});
  endtask
  task automatic drv(dsag_acc_e k, logic b, logic [15:0] ea, dsag_psh_e p);
    @(posedge clk);
    req <= '{k, b, 1'b0, 1'b0, 1'b0, ea, ~ea, p, pcVal};
  endtask
  // Avalon transfer held until waitrequest is seen low at an edge
  task automatic bus(logic wr, logic [3:0] ad, logic [15:0] d);
    logic w;
    @(posedge clk);
    avsAddress <= ad;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= {16'h0000, d};
    do
    begin
      @(posedge clk);
      w = avsWaitRequest;
      rd = avsReadData;
    end while (w);
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Compare due notes mid-cycle where outputs are settled
  always @(negedge clk)
  begin
    ncyc++;
    while (q.size() > 0 && q[0].due <= ncyc)
    begin
      `CHK(pick(q[0].sel), q[0].exp)
      void'(q.pop_front());
    end
  end
  // Watchdog
  initial
  begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    void'($urandom(32'h11ab));
    regOld <= 16'($urandom);
    pcVal = 24'($urandom);
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    // Limit readback, unmapped offset, then pushes past the limit
    bus(1'b1, OFS_STACK_LIMIT, 16'h0805);
    bus(1'b0, OFS_STACK_LIMIT, 16'h0000);
    `CHK(rd[15:0], 16'h0804)
    bus(1'b0, 4'h2, 16'h0000);
    `CHK(rd, 32'h0000_0000)
    bus(1'b1, OFS_STACK_PTR, 16'h0800);
    for (int i = 0; i < 4; i++)
    begin
      drv(ACC_PUSH, 1'b0, 16'h0000, PSH_DATA);
      note(5, 1, {8'h01, 16'h0800 + 16'(2 * i)});
      note(2, 2, {22'h0, 1'b0, i == 3});
    end
    drv(ACC_NONE, 1'b0, 16'h0000, PSH_DATA);
    // Pops down through the floor
    bus(1'b1, OFS_STACK_PTR, 16'h0802);
    for (int i = 0; i < 2; i++)
    begin
      drv(ACC_POP, 1'b0, 16'h0000, PSH_DATA);
      note(5, 1, {8'h00, 16'h0800 - 16'(2 * i)});
      note(2, 2, {22'h0, 1'b0, i == 1});
    end
    drv(ACC_NONE, 1'b0, 16'h0000, PSH_DATA);
    // Call and exception push words
    bus(1'b1, OFS_STACK_PTR, 16'h0900);
    bus(1'b1, OFS_STACK_LIMIT, 16'h0FFE);
    bus(1'b1, OFS_STATUS_LOW, 16'h005A);
    drv(ACC_PUSH, 1'b0, 16'h0000, PSH_CALL);
    note(6, 1, {16'h0000, 1'b0, pcVal[22:16]});
    drv(ACC_PUSH, 1'b0, 16'h0000, PSH_EXC);
    note(6, 1, {8'h00, 8'h5A, 1'b0, pcVal[22:16]});
    // Reads: word in Y region, byte, out of range, misaligned
    a = 16'h0800 | (16'($urandom) & 16'h07FE);
    m = mw(a);
    drv(ACC_READ, 1'b0, a, PSH_DATA);
    note(0, 2, {8'h00, m});
    drv(ACC_READ, 1'b1, a | 16'h0001, PSH_DATA);
    note(1, 2, {8'h00, regOld[15:8], m[15:8]});
    drv(ACC_READ, 1'b0, 16'h2000, PSH_DATA);
    note(0, 2, 24'h00_0000);
    drv(ACC_READ, 1'b0, a | 16'h0001, PSH_DATA);
    note(2, 2, 24'h00_0002);
    // Writes: misaligned suppressed, aligned on the X path
    drv(ACC_WRITE, 1'b0, a | 16'h0001, PSH_DATA);
    note(7, 1, 24'h00_0000);
    note(2, 2, 24'h00_0002);
    drv(ACC_WRITE, 1'b0, a, PSH_DATA);
    note(5, 1, {8'h01, a});
    note(6, 1, {8'h00, ~a});
    // Dual reads, X pointer into Y region then into X
    for (int i = 0; i < 2; i++)
    begin
      drv(ACC_MAC, 1'b0, 16'h0000, PSH_DATA);
      mac <= '{i ? 16'h0100 : 16'h0900, 16'h0A00};
      note(0, 2, {8'h00, i ? mw(16'h0100) : 16'h0000});
      note(4, 2, {8'h00, mw(16'h0A00)});
    end
    // Short direct field, reversal on writes only, modulo wrap
    @(posedge clk);
    req <= '{ACC_READ, 1'b0, 1'b1, 1'b0, 1'b0, 16'hE000 | a, ~a,
             PSH_DATA, pcVal};
    note(0, 2, {8'h00, m});
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      req <= '{i ? ACC_WRITE : ACC_READ, 1'b0, 1'b0, 1'b0, 1'b1,
               16'h0010, 16'h0000, PSH_DATA, pcVal};
      note(5, 1, {7'h00, i == 1, i ? 16'h0800 : 16'h0010});
    end
    drv(ACC_READ, 1'b0, 16'h0A10, PSH_DATA);
    modEnable <= 1'b1;
    note(0, 2, {8'h00, mw(16'h0A00)});
    drv(ACC_NONE, 1'b0, 16'h0000, PSH_DATA);
    modEnable <= 1'b0;
    // Program space: user, table user page, table config page
    for (int i = 0; i < 3; i++)
    begin
      pa = 24'($urandom);
      if (i == 2)
        bus(1'b1, OFS_TABLE_PAGE, 16'h0080);
      @(posedge clk);
      preq <= '{1'b1, i > 0, pa};
      note(3, 2, {i == 2, pa[22:1], 1'b0});
    end
    @(posedge clk);
    preq <= '0;
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule
bind dsag_agu dsag_agu_asserts #(.Y_BASE(Y_BASE), .Y_END(Y_END),
  .MEM_TOP(MEM_TOP)) chk (.clk(clk), .reset(reset),
  .avsAddress(avsAddress), .avsRead(avsRead), .avsReadData(avsReadData),
  .avsWaitRequest(avsWaitRequest), .req(req), .regOld(regOld),
  .mac(mac), .preq(preq), .yAddr(yAddr), .xWrite(xWrite),
  .xWdata(xWdata), .progAddr(progAddr), .xRdata(xRdata),
  .regLoad(regLoad), .addrErrTrap(addrErrTrap),
  .stackErrTrap(stackErrTrap));
